// File: src/pll_params.svh
// Constants of the synthesiser control core: field offsets, reset values and counts
// Behaviour
// - Serial bits enter the shift register on rising serial clock while enable is high.
// - Two low shift bits pick the target: first, second, swallow-only or reference.
// - Falling enable moves the shift register into the chosen buffer.
// - Shifting while enable is high leaves the running count cycle untouched.
// - Divider words keep the upper 22 bits: 19 counter bits, gain and sense.
// - Gain bits map to multipliers 1, 1.5, 2.5 and 4.
// - Sense set swaps phase detector inputs and the two monitor outputs.
// - Word select high makes the first word active, low the second.
// - Writing the inactive word never disturbs the running counters.
// - Divider word update only while more than 3 main counts remain, or at main count end.
// - Reference word uses the low 16 bits: ratio, output control, modulus select.
// - Output control bits set monitor outputs and pump on, off or lock gated.
// - Modulus bit one selects divide by 8/9, zero selects 16/17.
// - Reference word loads only while more than 1 reference count remains, or at reference cycle end.
// - Swallow-only update replaces the active swallow bits at main count end.
// - Each cycle with a nonzero swallow value starts on the larger modulus, smaller once swallow count completes.
// - Main counter counts prescaler outputs to its value, then both restart.
// - Swallow counter is 4 bits wide, main counter 15 bits wide.
// - Reference divider is 13 bits, ratio 1 to 8191, held in reference buffer.
// - Two detector flip-flops set by each pulse train, both cleared once both set.
// - Lock comes from filtered, thresholded exclusive-or of the divided signals.
// - Serial clock is ignored while enable is low.
// - Serial loader and buffers keep working in power-saving standby.
// - At each cycle end counters reload from the word chosen by word select.
`ifndef PLL_PARAMS_SVH
`define PLL_PARAMS_SVH

// ****************************************
// Shift register layout
// ****************************************
`define SHIFT_W 24
`define DIV_WORD_LSB 2
`define DIV_WORD_MSB 23
`define SWALLOW_LSB 2
`define SWALLOW_MSB 5
`define REF_WORD_LSB 2
`define REF_WORD_MSB 17

// ****************************************
// Reset values
// ****************************************
`define DIV_WORD_RST 22'h000640
`define REF_RATIO_RST 13'h0064
`define REF_OUT_RST 2'h1
`define REF_MOD_RST 1'h0
`define REF_WORD_RST {`REF_MOD_RST, `REF_OUT_RST, `REF_RATIO_RST}
`define LOCK_THR_RST 8'h10

// ****************************************
// Counts
// ****************************************
`define MAIN_GUARD 15'h0003
`define REF_GUARD 13'h0001
`define PRESC_SMALL 5'h08
`define PRESC_BIG 5'h10
`define LOCK_STEP 8'h04
`define LOCK_MAX 8'hFF

// ****************************************
// Register map
// ****************************************
`define OFS_STATUS 8'h00
`define OFS_LOCK_THR 8'h04
`define OFS_ACT_DIV 8'h08
`define OFS_REF_CFG 8'h0C
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: src/pll_pkg.sv
// Types shared by the synthesiser control core
package pll_pkg;
   typedef enum logic [1:0] {
      DEST_FIRST = 2'h0,
      DEST_SWALLOW = 2'h1,
      DEST_SECOND = 2'h2,
      DEST_REF = 2'h3
   } dest_t;

   typedef enum logic [1:0] {
      OUT_OFF_PUMP_ON = 2'h0,
      OUT_ON_PUMP_ON = 2'h1,
      OUT_ON_PUMP_OFF = 2'h2,
      OUT_ON_PUMP_LOCK = 2'h3
   } out_ctrl_t;

   typedef struct packed {
      logic sense;
      logic gainBitHigh;
      logic gainBitLow;
      logic [14:0] mainValue;
      logic [3:0] swallowValue;
   } div_word_t;

   typedef struct packed {
      logic modSmall;
      logic outputCtrlHigh;
      logic outputCtrlLow;
      logic [12:0] ratio;
   } ref_word_t;
endpackage : pll_pkg

// File: src/edge_if.sv
// Synchronised pin level with its edge strobes
`timescale 1ns/1ps
interface edge_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface : edge_if

// File: src/pin_sync.sv
// Two-stage synchroniser for one pin with edge detection
`timescale 1ns/1ps
module pin_sync
   import pll_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Pin and result
   input wire logic pinIn,
   edge_if.src edges
);
   logic meta, stable, prev;
   logic next_meta, next_stable, next_prev;

   always_comb begin
      next_meta = pinIn;
      next_stable = meta;
      next_prev = stable;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta <= 1'b0;
         stable <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= next_meta;
         stable <= next_stable;
         prev <= next_prev;
      end
   end

   // Edges look only at the second and third stages
   assign edges.level = stable;
   assign edges.rise = stable & ~prev;
   assign edges.fall = ~stable & prev;
endmodule : pin_sync

// File: src/ref_divider.sv
// Programmable 13-bit reference divider with guarded ratio load
`timescale 1ns/1ps
`include "pll_params.svh"
module ref_divider
   import pll_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Reference edges
   input wire logic refTick,
   input wire logic run,
   // Ratio load
   input wire logic [12:0] ratioIn,
   input wire logic loadReq,
   output logic loadAck,
   // Divided output
   output logic refPulse
);
   logic [12:0] cnt, ratio;
   logic [12:0] next_cnt, next_ratio;
   logic next_refPulse;
   logic [12:0] effRatio;
   logic endTick;

   // Ratio zero behaves as one
   assign effRatio = (ratio == 13'h0000) ? 13'h0001 : ratio;
   assign endTick = run & refTick & ((cnt + 13'h0001) >= effRatio);
   // A cycle boundary is always a safe load point, so ratio 1 can still be changed
   assign loadAck = loadReq & (((effRatio - cnt) > `REF_GUARD) | endTick);

   always_comb begin
      next_cnt = cnt;
      next_ratio = ratio;
      next_refPulse = 1'b0;
      if (run & refTick) begin
         next_cnt = endTick ? 13'h0000 : cnt + 13'h0001;
         next_refPulse = endTick;
      end
      if (loadAck) begin
         next_ratio = ratioIn;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt <= 13'h0000;
         ratio <= `REF_RATIO_RST;
         refPulse <= 1'b0;
      end else begin
         cnt <= next_cnt;
         ratio <= next_ratio;
         refPulse <= next_refPulse;
      end
   end
endmodule : ref_divider

// File: src/pll_divider_serial_control.sv
// Digital core of the synthesiser: serial loader, dividers, phase detector, lock, AXI4-Lite
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "pll_params.svh"
module pll_divider_serial_control
   import pll_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // AXI4-Lite write
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Serial programming pins
   input wire logic serData,
   input wire logic serClk,
   input wire logic loadEnable,
   input wire logic wordSelectPin,
   input wire logic powerDown,
   // Signal inputs
   input wire logic rfIn,
   input wire logic refIn,
   // Pump and monitors
   output logic pumpSource,
   output logic pumpSink,
   output logic [3:0] pumpGainHalves,
   output logic rfMonitor,
   output logic refMonitor,
   output logic lockSink
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   edge_if dataE ();
   edge_if clkE ();
   edge_if enE ();
   edge_if selE ();
   edge_if pdE ();
   edge_if rfE ();
   edge_if refE ();

   pin_sync dataSync (.clk(clk), .sys_rst(sys_rst), .pinIn(serData), .edges(dataE));
   pin_sync clkSync (.clk(clk), .sys_rst(sys_rst), .pinIn(serClk), .edges(clkE));
   pin_sync enSync (.clk(clk), .sys_rst(sys_rst), .pinIn(loadEnable), .edges(enE));
   pin_sync selSync (.clk(clk), .sys_rst(sys_rst), .pinIn(wordSelectPin), .edges(selE));
   pin_sync pdSync (.clk(clk), .sys_rst(sys_rst), .pinIn(powerDown), .edges(pdE));
   pin_sync rfSync (.clk(clk), .sys_rst(sys_rst), .pinIn(rfIn), .edges(rfE));
   pin_sync refSync (.clk(clk), .sys_rst(sys_rst), .pinIn(refIn), .edges(refE));

   // Gain multiplier in half steps
   function automatic logic [3:0] gain_halves(input logic high, input logic low);
      case ({high, low})
         2'h0: gain_halves = 4'h2;
         2'h2: gain_halves = 4'h3;
         2'h1: gain_halves = 4'h5;
         default: gain_halves = 4'h8;
      endcase
   endfunction : gain_halves

   // ****************************************
   // State
   // ****************************************
   logic [23:0] shiftReg, next_shiftReg;
   div_word_t firstWord, secondWord, divStage;
   div_word_t next_firstWord, next_secondWord, next_divStage;
   logic divPend, divToFirst, next_divPend, next_divToFirst;
   logic [3:0] swStage, next_swStage;
   logic swPend, next_swPend;
   ref_word_t refWord, refStage, next_refWord, next_refStage;
   logic refPend, next_refPend;
   logic [4:0] prescCnt, next_prescCnt;
   logic [3:0] swCnt, next_swCnt;
   logic [14:0] mainCnt, next_mainCnt;
   logic [14:0] actM, next_actM;
   logic [3:0] actA, next_actA;
   logic bigMod, next_bigMod;
   logic rfPulse, next_rfPulse;
   logic upFf, downFf, next_upFf, next_downFf;
   logic [7:0] lockLevel, next_lockLevel;
   logic locked, next_locked;
   logic [7:0] lockThr;
   logic next_pumpSource, next_pumpSink, next_rfMonitor, next_refMonitor;
   logic [3:0] next_pumpGainHalves;
   logic refPulse, refLoadAck, running;

   div_word_t act;
   logic [4:0] modN, presLimit;
   logic presOut, cycleEnd, pumpOn, outOn, srcSet, sinkSet;
   logic [14:0] effM, mainInc;
   out_ctrl_t outCtrl;

   assign running = ~pdE.level;
   assign act = selE.level ? firstWord : secondWord;
   assign modN = refWord.modSmall ? `PRESC_SMALL : `PRESC_BIG;
   assign presLimit = bigMod ? modN + 5'h01 : modN;
   assign presOut = running & rfE.rise & ((prescCnt + 5'h01) >= presLimit);
   assign effM = (actM == 15'h0000) ? 15'h0001 : actM;
   assign mainInc = mainCnt + 15'h0001;
   assign cycleEnd = presOut & (mainInc >= effM);
   assign outCtrl = out_ctrl_t'({refWord.outputCtrlHigh, refWord.outputCtrlLow});

   ref_divider refDiv (
      .clk(clk),
      .sys_rst(sys_rst),
      .refTick(refE.rise),
      .run(running),
      .ratioIn(refStage.ratio),
      .loadReq(refPend),
      .loadAck(refLoadAck),
      .refPulse(refPulse)
   );

   // ****************************************
   // Loader, dividers and detector
   // ****************************************
   always_comb begin
      next_shiftReg = shiftReg;
      next_firstWord = firstWord;
      next_secondWord = secondWord;
      next_divStage = divStage;
      next_divPend = divPend;
      next_divToFirst = divToFirst;
      next_swStage = swStage;
      next_swPend = swPend;
      next_refWord = refWord;
      next_refStage = refStage;
      next_refPend = refPend;
      next_prescCnt = prescCnt;
      next_swCnt = swCnt;
      next_mainCnt = mainCnt;
      next_actM = actM;
      next_actA = actA;
      next_bigMod = bigMod;
      next_rfPulse = 1'b0;

      // Loader runs regardless of standby
      if (enE.level & clkE.rise) begin
         next_shiftReg = {shiftReg[22:0], dataE.level};
      end
      if (enE.fall) begin
         unique case (dest_t'(shiftReg[1:0]))
            DEST_FIRST, DEST_SECOND: begin
               next_divStage = div_word_t'(shiftReg[`DIV_WORD_MSB:`DIV_WORD_LSB]);
               next_divToFirst = (shiftReg[1:0] == DEST_FIRST);
               next_divPend = 1'b1;
            end
            DEST_SWALLOW: begin
               next_swStage = shiftReg[`SWALLOW_MSB:`SWALLOW_LSB];
               next_swPend = 1'b1;
            end
            DEST_REF: begin
               next_refStage = ref_word_t'(shiftReg[`REF_WORD_MSB:`REF_WORD_LSB]);
               next_refPend = 1'b1;
            end
         endcase
      end

      // Divider word commit waits for a safe point in the count
      if (divPend & (((effM - mainCnt) > `MAIN_GUARD) | cycleEnd)) begin
         if (divToFirst) begin
            next_firstWord = divStage;
         end else begin
            next_secondWord = divStage;
         end
         // Stay pending only for a fresh divider word, not any other load
         next_divPend = enE.fall & ~shiftReg[0];
      end

      if (refLoadAck) begin
         next_refWord = refStage;
         next_refPend = enE.fall & (shiftReg[1:0] == 2'h3);
      end

      // Prescaler and swallow/main chain
      if (running & rfE.rise) begin
         next_prescCnt = presOut ? 5'h00 : prescCnt + 5'h01;
      end
      if (presOut) begin
         if (bigMod) begin
            next_swCnt = swCnt + 4'h1;
            if ((swCnt + 4'h1) == actA) begin
               next_bigMod = 1'b0;
            end
         end
         next_mainCnt = mainInc;
      end
      if (cycleEnd) begin
         if (swPend) begin
            if (selE.level) begin
               next_firstWord.swallowValue = swStage;
            end else begin
               next_secondWord.swallowValue = swStage;
            end
            next_swPend = enE.fall & (shiftReg[1:0] == 2'h1);
         end
         // Reload sees commits made on this same edge
         next_actM = selE.level ? next_firstWord.mainValue : next_secondWord.mainValue;
         next_actA = selE.level ? next_firstWord.swallowValue
                                : next_secondWord.swallowValue;
         next_swCnt = 4'h0;
         next_mainCnt = 15'h0000;
         next_bigMod = (next_actA != 4'h0);
         next_rfPulse = 1'b1;
      end
   end

   always_comb begin
      // Detector edges swap with sense
      srcSet = act.sense ? rfPulse : refPulse;
      sinkSet = act.sense ? refPulse : rfPulse;
      next_upFf = upFf | srcSet;
      next_downFf = downFf | sinkSet;
      if (next_upFf & next_downFf) begin
         next_upFf = 1'b0;
         next_downFf = 1'b0;
      end

      // Leaky integrator of the phase exclusive-or
      next_lockLevel = lockLevel;
      if (upFf ^ downFf) begin
         next_lockLevel = (lockLevel > (`LOCK_MAX - `LOCK_STEP)) ? `LOCK_MAX
                                                                : lockLevel + `LOCK_STEP;
      end else if (lockLevel != 8'h00) begin
         next_lockLevel = lockLevel - 8'h01;
      end
      next_locked = (lockLevel < lockThr);

      unique case (outCtrl)
         OUT_OFF_PUMP_ON: begin
            outOn = 1'b0;
            pumpOn = 1'b1;
         end
         OUT_ON_PUMP_ON: begin
            outOn = 1'b1;
            pumpOn = 1'b1;
         end
         OUT_ON_PUMP_OFF: begin
            outOn = 1'b1;
            pumpOn = 1'b0;
         end
         OUT_ON_PUMP_LOCK: begin
            outOn = 1'b1;
            pumpOn = ~locked;
         end
      endcase
      next_pumpSource = next_upFf & pumpOn;
      next_pumpSink = next_downFf & pumpOn;
      next_pumpGainHalves = gain_halves(act.gainBitHigh, act.gainBitLow);
      next_rfMonitor = outOn & (act.sense ? refPulse : rfPulse);
      next_refMonitor = outOn & (act.sense ? rfPulse : refPulse);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         shiftReg <= 24'h000000;
         firstWord <= div_word_t'(`DIV_WORD_RST);
         secondWord <= div_word_t'(`DIV_WORD_RST);
         divStage <= div_word_t'(`DIV_WORD_RST);
         divPend <= 1'b0;
         divToFirst <= 1'b0;
         swStage <= 4'h0;
         swPend <= 1'b0;
         refWord <= ref_word_t'(`REF_WORD_RST);
         refStage <= ref_word_t'(`REF_WORD_RST);
         refPend <= 1'b0;
         prescCnt <= 5'h00;
         swCnt <= 4'h0;
         mainCnt <= 15'h0000;
         actM <= 15'h0001;
         actA <= 4'h0;
         bigMod <= 1'b0;
         rfPulse <= 1'b0;
         upFf <= 1'b0;
         downFf <= 1'b0;
         lockLevel <= `LOCK_MAX;
         locked <= 1'b0;
         pumpSource <= 1'b0;
         pumpSink <= 1'b0;
         pumpGainHalves <= 4'h2;
         rfMonitor <= 1'b0;
         refMonitor <= 1'b0;
      end else begin
         shiftReg <= next_shiftReg;
         firstWord <= next_firstWord;
         secondWord <= next_secondWord;
         divStage <= next_divStage;
         divPend <= next_divPend;
         divToFirst <= next_divToFirst;
         swStage <= next_swStage;
         swPend <= next_swPend;
         refWord <= next_refWord;
         refStage <= next_refStage;
         refPend <= next_refPend;
         prescCnt <= next_prescCnt;
         swCnt <= next_swCnt;
         mainCnt <= next_mainCnt;
         actM <= next_actM;
         actA <= next_actA;
         bigMod <= next_bigMod;
         rfPulse <= next_rfPulse;
         upFf <= next_upFf;
         downFf <= next_downFf;
         lockLevel <= next_lockLevel;
         locked <= next_locked;
         pumpSource <= next_pumpSource;
         pumpSink <= next_pumpSink;
         pumpGainHalves <= next_pumpGainHalves;
         rfMonitor <= next_rfMonitor;
         refMonitor <= next_refMonitor;
      end
   end

   assign lockSink = locked;

   // ****************************************
   // AXI4-Lite slave
   // ****************************************
   logic awHeld, wHeld, next_awHeld, next_wHeld;
   logic [7:0] awAddr, next_awAddr;
   logic [31:0] wData, next_wData;
   logic [3:0] wStrb, next_wStrb;
   logic [7:0] next_lockThr;
   logic next_bvalid, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;

   assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
   assign s_axi_wready = ~wHeld & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   always_comb begin
      next_awHeld = awHeld;
      next_wHeld = wHeld;
      next_awAddr = awAddr;
      next_wData = wData;
      next_wStrb = wStrb;
      next_lockThr = lockThr;
      next_bvalid = s_axi_bvalid & ~s_axi_bready;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid & ~s_axi_rready;
      next_rresp = s_axi_rresp;
      next_rdata = s_axi_rdata;
      if (s_axi_awvalid & s_axi_awready) begin
         next_awHeld = 1'b1;
         next_awAddr = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid & s_axi_wready) begin
         next_wHeld = 1'b1;
         next_wData = s_axi_wdata;
         next_wStrb = s_axi_wstrb;
      end
      if (awHeld & wHeld) begin
         next_awHeld = 1'b0;
         next_wHeld = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = `RESP_SLVERR;
         if (awAddr == `OFS_LOCK_THR) begin
            next_bresp = `RESP_OKAY;
            if (wStrb[0]) begin
               next_lockThr = wData[7:0];
            end
         end
      end
      if (s_axi_arvalid & s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp = `RESP_OKAY;
         case (s_axi_araddr[7:0])
            `OFS_STATUS: next_rdata = {26'h0000000, pdE.level, pumpSink, pumpSource,
                                       refWord.modSmall, selE.level, locked};
            `OFS_LOCK_THR: next_rdata = {24'h000000, lockThr};
            `OFS_ACT_DIV: next_rdata = {13'h0000, actM, actA};
            `OFS_REF_CFG: next_rdata = {16'h0000, refWord};
            default: begin
               next_rdata = 32'h00000000;
               next_rresp = `RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 8'h00;
         wData <= 32'h00000000;
         wStrb <= 4'h0;
         lockThr <= `LOCK_THR_RST;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
      end else begin
         awHeld <= next_awHeld;
         wHeld <= next_wHeld;
         awAddr <= next_awAddr;
         wData <= next_wData;
         wStrb <= next_wStrb;
         lockThr <= next_lockThr;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp <= next_rresp;
         s_axi_rdata <= next_rdata;
      end
   end
endmodule : pll_divider_serial_control

// File: testbench/pll_checker.sv
// Port-level assertions for the synthesiser control core
`timescale 1ns/1ps
module pll_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // Pump and monitor
   input wire logic pumpSource,
   input wire logic pumpSink,
   input wire logic [3:0] pumpGainHalves,
   input wire logic rfMonitor
);
   // ****************
   // Checks
   // ****************
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence wPair;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   AST_RST: assert property (disable iff (1'b0)
      sys_rst |=> !s_axi_bvalid && !s_axi_rvalid && pumpGainHalves == 4'h2)
      else $error("outputs not cleared by reset");
   AST_B_LAT: assert property (wPair |-> ##2 s_axi_bvalid)
      else $error("write response late");
   AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during data");
   AST_PD_CLR: assert property (!(pumpSource && pumpSink))
      else $error("pump source and sink both on");
   AST_GAIN: assert property (pumpGainHalves inside {4'h2, 4'h3, 4'h5, 4'h8})
      else $error("illegal gain code");
   AST_RF_PULSE: assert property ($rose(rfMonitor) |=> $fell(rfMonitor))
      else $error("divided pulse too long");
endmodule : pll_checker

bind pll_divider_serial_control pll_checker u_chk (.*);

// File: testbench/host_model.sv
// Behavioural host driving the three-wire serial programming lines
`timescale 1ns/1ps
module host_model (
   // Clock
   input wire logic clk,
   // Serial lines
   output logic serData,
   output logic serClk,
   output logic loadEnable
);
   // ****************
   // Serial frames
   // ****************
   // Serial clock stands low outside frames
   initial begin
      serData = 1'b0;
      serClk = 1'b0;
      loadEnable = 1'b0;
   end
   // Half period of four clocks gives the 800 ns link rate
   task automatic send(input logic [23:0] w, input int n);
      @(posedge clk);
      loadEnable <= 1'b1;
      for (int i = n - 1; i >= 0; i--) begin
         serData <= w[i];
         repeat (4) @(posedge clk);
         serClk <= 1'b1;
         repeat (4) @(posedge clk);
         serClk <= 1'b0;
      end
      repeat (4) @(posedge clk);
      loadEnable <= 1'b0;
      // Released line shows the inverse so stale bits cannot pass
      serData <= ~serData;
   endtask : send
endmodule : host_model

// File: testbench/tb_top.sv
// Bench for the synthesiser control core
`timescale 1ns/1ps
`include "pll_params.svh"
module tb_top;
   logic clk = 1'b0, sys_rst = 1'b1, wordSelectPin = 1'b1, powerDown = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rfIn = 1'b0, refIn = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF, pumpGainHalves;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, lockSink;
   logic serData, serClk, loadEnable, pumpSource, pumpSink, rfMonitor, refMonitor;
   int nMismatch = 0, checked = 0, cyc = 0, n;
   pll_divider_serial_control u_dut (.*);
   host_model u_host (.*);
   // ****************
   // Stimulus and tasks
   // ****************
   initial forever #50 clk = ~clk;
   // RF period 6 clocks, reference period 10 clocks
   always @(posedge clk) begin
      cyc <= cyc + 1;
      rfIn <= (cyc % 6) < 3;
      refIn <= (cyc % 10) < 5;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         nMismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, r});
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, d);
      chk({30'h0, s_axi_rresp}, {30'h0, r});
   endtask : rd
   task automatic wt(input bit useRf, input int k);
      repeat (k) @(posedge clk iff (useRf ? rfMonitor : refMonitor));
   endtask : wt
   task automatic gap(input bit useRf, input int exp);
      wt(useRf, 1);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!(useRf ? rfMonitor : refMonitor));
      chk(n, exp);
   endtask : gap
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", checked, nMismatch);
      if (nMismatch == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize
   initial begin
      repeat (60000) @(posedge clk);
      nMismatch++;
      summarize();
   end
   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd(`OFS_LOCK_THR, {24'h0, `LOCK_THR_RST}, `RESP_OKAY);
      wr(`OFS_LOCK_THR, 32'h20, `RESP_OKAY);
      rd(`OFS_LOCK_THR, 32'h20, `RESP_OKAY);
      wr(`OFS_ACT_DIV, 32'h1, `RESP_SLVERR);
      rd(32'h10, 32'h0, `RESP_SLVERR);
      $display("registers finished");
      u_host.send({6'h0, 1'b1, 2'b01, 13'h5, 2'b11}, 24);
      wt(0, 3);
      rd(`OFS_REF_CFG, 32'hA005, `RESP_OKAY);
      gap(0, 50);
      $display("reference finished");
      u_host.send({3'b010, 15'h14, 4'h3, 2'b00}, 24);
      wt(1, 3);
      rd(`OFS_ACT_DIV, 32'h143, `RESP_OKAY);
      chk({28'h0, pumpGainHalves}, 32'h3);
      u_host.send({3'b011, 15'h1E, 4'h5, 2'b10}, 24);
      wt(1, 2);
      rd(`OFS_ACT_DIV, 32'h143, `RESP_OKAY);
      wordSelectPin <= 1'b0;
      wt(1, 3);
      rd(`OFS_ACT_DIV, 32'h1E5, `RESP_OKAY);
      chk({28'h0, pumpGainHalves}, 32'h8);
      u_host.send({18'h0, 4'h7, 2'b01}, 6);
      wt(1, 3);
      rd(`OFS_ACT_DIV, 32'h1E7, `RESP_OKAY);
      gap(1, 1482);
      $display("dividers finished");
      u_host.send({3'b111, 15'h1E, 4'h7, 2'b10}, 24);
      repeat (3500) @(posedge clk);
      gap(1, 50);
      $display("sense finished");
      u_host.send({6'h0, 1'b1, 2'b10, 13'h5, 2'b11}, 24);
      wt(1, 2);
      chk({30'h0, pumpSource, pumpSink}, 32'h0);
      chk({31'h0, lockSink}, 32'h0);
      powerDown <= 1'b1;
      u_host.send({18'h0, 4'h6, 2'b01}, 6);
      powerDown <= 1'b0;
      wt(0, 2);
      rd(`OFS_ACT_DIV, 32'h1E6, `RESP_OKAY);
      $display("standby finished");
      summarize();
   end
endmodule : tb_top
